// ==== bench/edr_chk.sv ====
// checker: request level, gap and strobe timing seen on the shared bus
`timescale 1ns/1ps
module edr_chk
  import edr_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        bus_mode_select,
  input wire logic [7:0]  dedicated_address_pins,
  input wire logic [15:0] data_from_master,
  input wire logic [15:0] data_from_device,
  input wire logic        data_oe_device,
  input wire logic        ale,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        transfer_request,
  input wire logic        transfer_acknowledge
);
  logic [7:0]  ctl_q, pol_q, gap_q, adr_q, la_q;
  logic [15:0] wd_q;
  logic        wr_q, ale_q, lcs_q, sel_q;
  logic [3:0]  stab_q, rdl_q;
  logic [11:0] idle_q;
  logic        act, ack_on;
  assign act    = (transfer_request == pol_q[EDR_POL_REQ_HIGH]);
  assign ack_on = (transfer_acknowledge != pol_q[EDR_POL_ACK_LOW]);
  ////////////////////////////////////////////////////////////////////////
  // config mirror decoded from the pins, so no hook into the device body
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {wr_q, ale_q, lcs_q, sel_q} <= 4'b1010;
      {la_q, adr_q, wd_q} <= '0;
      {ctl_q, pol_q, gap_q} <= {EDR_CTL_RESET, EDR_POL_RESET, EDR_GAP_RESET};
      stab_q <= '0;
    end else begin
      wr_q <= wr_n;
      ale_q <= ale;
      wd_q <= data_from_master;
      sel_q <= bus_mode_select ? !lcs_q : !cs_n;
      adr_q <= bus_mode_select ? la_q : dedicated_address_pins;
      if (ale_q && !ale) begin
        // bus already carries data at the edge that shows the fall
        la_q <= wd_q[7:0];
        lcs_q <= cs_n;
      end
      if (wr_n && !wr_q && sel_q) begin
        stab_q <= '0;
        if (adr_q == EDR_DMA_TRANSFER_CONTROL_ADDR) ctl_q <= wd_q[7:0];
        if (adr_q == EDR_SIGNAL_POLARITY_SELECT_ADDR) pol_q <= wd_q[7:0];
        if (adr_q == EDR_REQUEST_GAP_INTERVAL_ADDR) gap_q <= wd_q[7:0];
      end else if (stab_q != 4'hf) stab_q <= stab_q + 4'h1;
    end
  end
  // idle length of the request and age of the last read strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 12'hfff;
      rdl_q <= 4'hf;
    end else begin
      idle_q <= act ? 12'h000 : (idle_q == 12'hfff ? idle_q : idle_q + 12'h001);
      rdl_q <= !rd_n ? 4'h0 : (rdl_q == 4'hf ? rdl_q : rdl_q + 4'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_reset_req_idle: assert property ($rose(arst_n) |-> transfer_request)
    else $error("request not idle high after reset");
  a_off_no_req: assert property (stab_q == 4'hf && !ctl_q[EDR_CTL_ENABLE] |-> !act)
    else $error("request active while dma disabled");
  a_halt_no_req: assert property (stab_q == 4'hf && ctl_q[EDR_CTL_HALT] |-> !act)
    else $error("request active while halted");
  a_single_unit_drop: assert property (ctl_q[EDR_CTL_ENABLE] && !ctl_q[EDR_CTL_DEMAND]
    && !ctl_q[EDR_CTL_DUAL] && $fell(rd_n) && ack_on |-> ##[1:8] !act)
    else $error("single mode request held after a unit");
  a_gap_wait_min: assert property (ctl_q[EDR_CTL_ENABLE] && !ctl_q[EDR_CTL_DEMAND]
    && stab_q == 4'hf && $rose(act) |-> idle_q >= 12'(gap_q * EDR_BIT_CYCLES))
    else $error("request gap shorter than programmed");
  a_oe_after_read: assert property (data_oe_device |-> rdl_q < 4'h6)
    else $error("device drives data without a read");
  a_no_drive_write: assert property (!wr_n |-> !data_oe_device)
    else $error("device drives data during a write");
  a_read_strobe_len: assert property ($fell(rd_n) |-> !rd_n [*4])
    else $error("read strobe shorter than four cycles");
  c_req_rise: cover property ($rose(act));
  c_demand_read: cover property (ctl_q[EDR_CTL_DEMAND] && act && !rd_n);
  c_wide_drive: cover property (data_oe_device && ctl_q[EDR_CTL_WIDE]);
endmodule : edr_chk

// ==== bench/endpoint_dma_request_logic_tb_top.sv ====
// testbench: both ends joined, software port and usb events driven in fixed order, counts and data at random
`timescale 1ns/1ps
module endpoint_dma_request_logic_tb_top;
  import edr_pkg::*;
  logic        core_clk, arst_n, usb_rx_good, usb_tx_acked, ep_is_in, sw_wr, sw_rd;
  logic [6:0]  usb_rx_count, c;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata, sw_rdata, r;
  logic        tx_packet_ready, rx_packet_ready;
  logic [7:0]  pol, ctl;
  int          mismatches, comparisons, i, v, n, k;
  integer      seed;
  edr_if bus_if ();
  edr_device edr_device_inst (.core_clk(core_clk), .arst_n(arst_n), .bus(bus_if),
    .usb_rx_good(usb_rx_good), .usb_rx_count(usb_rx_count), .usb_tx_acked(usb_tx_acked),
    .ep_is_in(ep_is_in), .tx_packet_ready(tx_packet_ready), .rx_packet_ready(rx_packet_ready));
  edr_master edr_master_inst (.core_clk(core_clk), .arst_n(arst_n), .bus(bus_if),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  edr_chk edr_chk_inst (.core_clk(core_clk), .arst_n(arst_n),
    .bus_mode_select(bus_if.bus_mode_select), .dedicated_address_pins(bus_if.dedicated_address_pins),
    .data_from_master(bus_if.data_from_master), .data_from_device(bus_if.data_from_device),
    .data_oe_device(bus_if.data_oe_device), .ale(bus_if.ale), .cs_n(bus_if.cs_n),
    .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .transfer_request(bus_if.transfer_request),
    .transfer_acknowledge(bus_if.transfer_acknowledge));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic sw_w(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask : sw_w
  // read data stands from the cycle after the strobe until the next read
  task automatic sw_r(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_r
  task automatic dev_op(input logic [7:0] a, input logic [15:0] wd, input logic [2:0] cmd,
                        output logic [15:0] rd);
    logic [15:0] s;
    int j;
    sw_w(EDR_HOST_ADDR_REG, {8'h00, a});
    sw_w(EDR_HOST_DATA_REG, wd);
    sw_w(EDR_HOST_CMD_REG, {13'h0000, cmd});
    s = 16'h0001;
    for (j = 0; j < 400 && s[0] !== 1'b0; j++) sw_r(EDR_HOST_STAT_REG, s);
    chk({15'h0000, s[0]}, 16'h0000, "bus cycle never completed");
    if (s[0] !== 1'b0) summarize();
    sw_r(EDR_HOST_RDATA_REG, rd);
  endtask : dev_op
  task automatic expect_req(input logic act, input string msg);
    logic e;
    int j;
    e = pol[EDR_POL_REQ_HIGH] ? act : !act;
    @(negedge core_clk);
    for (j = 0; j < 64 && bus_if.transfer_request !== e; j++) @(negedge core_clk);
    chk({15'h0000, bus_if.transfer_request}, {15'h0000, e}, msg);
  endtask : expect_req
  // no waiting: the level must already stand
  task automatic req_now(input logic act, input string msg);
    chk({15'h0000, bus_if.transfer_request}, {15'h0000, act ~^ pol[EDR_POL_REQ_HIGH]}, msg);
  endtask : req_now
  // polarity first, so the polarity write itself runs while the master's acknowledge is still idle for the device
  task automatic pol_set(input logic [7:0] p, input logic mux);
    logic [15:0] q;
    dev_op(EDR_SIGNAL_POLARITY_SELECT_ADDR, {8'h00, p}, 3'd1, q);
    sw_w(EDR_HOST_MODE_REG, {14'h0000, p[EDR_POL_ACK_LOW], mux});
    pol = p;
  endtask : pol_set
  task automatic pulse(input logic rx);
    @(posedge core_clk);
    usb_rx_good <= rx;
    usb_tx_acked <= !rx;
    usb_rx_count <= c;
    @(posedge core_clk);
    {usb_rx_good, usb_tx_acked} <= 2'b00;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    chk(16'h0001, 16'h0000, "run limit reached");
    summarize();
  end
  initial begin
    {arst_n, usb_rx_good, usb_tx_acked, ep_is_in, sw_wr, sw_rd} = '0;
    {usb_rx_count, sw_addr, sw_wdata, c} = '0;
    {mismatches, comparisons} = '0;
    pol = 8'h00;
    seed = 37;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    expect_req(1'b0, "request idle after reset");
    for (i = 0; i < 3; i++) begin
      dev_op(EDR_DMA_TRANSFER_CONTROL_ADDR + 8'(i), 16'h0000, 3'd2, r);
      chk({8'h00, r[7:0]}, 16'h0000, "config reset value");
    end
    dev_op(8'h7f, 16'h0000, 3'd2, r);
    chk(r, 16'h0000, "unmapped read");
    $display("test reset done");
    // multiplexed then separate access to the same register
    pol_set(8'h00, 1'b1);
    k = ($random(seed) & 1) + 1;
    dev_op(EDR_REQUEST_GAP_INTERVAL_ADDR, 16'(k), 3'd1, r);
    dev_op(EDR_REQUEST_GAP_INTERVAL_ADDR, 16'h0000, 3'd2, r);
    chk({8'h00, r[7:0]}, 16'(k), "gap readback multiplexed");
    pol_set(8'h02, 1'b0);
    expect_req(1'b0, "idle request active high");
    dev_op(EDR_REQUEST_GAP_INTERVAL_ADDR, 16'h0000, 3'd2, r);
    chk({8'h00, r[7:0]}, 16'(k), "gap readback separate");
    $display("test bus modes done");
    for (v = 0; v < 4; v++) begin
      ep_is_in <= 1'b0;
      pol_set(v[1] ? 8'h06 : 8'h00, 1'b0);
      c = 7'(($random(seed) & 7) + 1) | 7'(v == 1);
      // last pass runs dual address mode: fifo reached by address, not acknowledge
      ctl = {3'b000, v[1], v[0], 1'b1, v[1] & v[0], 1'b0};
      dev_op(EDR_DMA_TRANSFER_CONTROL_ADDR, {8'h00, ctl}, 3'd1, r);
      pulse(1'b1);
      chk({15'h0000, rx_packet_ready}, 16'h0001, "rx ready after good packet");
      expect_req(1'b0, "request gated off");
      dev_op(EDR_DMA_TRANSFER_CONTROL_ADDR, {8'h00, ctl | 8'h01}, 3'd1, r);
      expect_req(1'b1, "rx request");
      n = v[0] ? (c + 1) / 2 : c;
      for (i = 0; i <= n; i++) begin
        dev_op(EDR_FIFO_ADDR, 16'h0000, (v == 3) ? 3'd2 : 3'd6, r);
        if (i == 0) chk(v[0] ? r : {8'h00, r[7:0]}, {9'h000, c}, "byte count unit");
        if (i == 0 && v[1]) req_now(1'b1, "demand request held");
        if (i == 0 && !v[1]) req_now(1'b0, "single request in gap");
        if (i == n && v[0] && c[0]) chk({8'h00, r[15:8]}, 16'h0000, "odd tail upper");
      end
      for (k = 0; k < 16 && rx_packet_ready !== 1'b0; k++) @(negedge core_clk);
      chk({15'h0000, rx_packet_ready}, 16'h0000, "rx ready cleared");
      expect_req(1'b0, "rx request dropped");
      dev_op(EDR_DMA_TRANSFER_CONTROL_ADDR, 16'h0000, 3'd1, r);
    end
    $display("test receive done");
    pol_set(8'h00, 1'b0);
    ep_is_in <= 1'b1;
    dev_op(EDR_DMA_TRANSFER_CONTROL_ADDR, 16'h0001, 3'd1, r);
    expect_req(1'b1, "tx request");
    for (i = 0; i < 64; i++) begin
      if (i == 20) begin
        dev_op(EDR_DMA_TRANSFER_CONTROL_ADDR, 16'h0081, 3'd1, r);
        expect_req(1'b0, "halted");
        repeat (20) @(posedge core_clk);
        dev_op(EDR_DMA_TRANSFER_CONTROL_ADDR, 16'h0001, 3'd1, r);
        expect_req(1'b1, "resumed");
      end
      dev_op(EDR_FIFO_ADDR, 16'($random(seed)), 3'd5, r);
      if (i == 62) chk({15'h0000, tx_packet_ready}, 16'h0000, "tx ready early");
    end
    for (k = 0; k < 16 && tx_packet_ready !== 1'b1; k++) @(negedge core_clk);
    chk({15'h0000, tx_packet_ready}, 16'h0001, "tx ready on full packet");
    expect_req(1'b0, "tx request dropped");
    pulse(1'b0);
    chk({15'h0000, tx_packet_ready}, 16'h0000, "tx ready cleared by ack");
    expect_req(1'b1, "tx request again");
    for (i = 0; i < 3; i++) dev_op(EDR_FIFO_ADDR, 16'($random(seed)), 3'd5, r);
    dev_op(EDR_PKT_READY_ADDR, 16'h0020, 3'd1, r);
    repeat (6) @(negedge core_clk);
    chk({15'h0000, tx_packet_ready}, 16'h0001, "short packet ready");
    expect_req(1'b0, "short packet request dropped");
    $display("test transmit done");
    summarize();
  end
endmodule : endpoint_dma_request_logic_tb_top

// ==== core/edr_device.sv ====
// device end: local bus slave, first bulk endpoint fifo and dma request logic
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module edr_device
  import edr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  edr_if.device           bus,
  input  wire logic       usb_rx_good,
  input  wire logic [6:0] usb_rx_count,
  input  wire logic       usb_tx_acked,
  input  wire logic       ep_is_in,
  output logic            tx_packet_ready,
  output logic            rx_packet_ready
);
  import edr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] ale_s, rd_s, wr_s, ack_s, cs_s, mode_s;
  // mux address delayed to line up with ale_d1: the pins carry data by the time the fall shows
  logic [7:0] ad_p1_q, ad_p2_q, ad_p3_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ale_s <= 2'h0; rd_s <= 2'h3; wr_s <= 2'h3; ack_s <= 2'h0;
      cs_s <= 2'h3; mode_s <= 2'h0;
    end else begin
      ale_s  <= {ale_s[0], bus.ale};
      rd_s   <= {rd_s[0], bus.rd_n};
      wr_s   <= {wr_s[0], bus.wr_n};
      ack_s  <= {ack_s[0], bus.transfer_acknowledge};
      cs_s   <= {cs_s[0], bus.cs_n};
      mode_s <= {mode_s[0], bus.bus_mode_select};
    end
  end
  logic ale_d1, rd_d1, wr_d1;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ale_d1 <= 1'b0; rd_d1 <= 1'b1; wr_d1 <= 1'b1;
      ad_p1_q <= 8'h00;
      ad_p2_q <= 8'h00;
      ad_p3_q <= 8'h00;
    end else begin
      ale_d1 <= ale_s[1]; rd_d1 <= rd_s[1]; wr_d1 <= wr_s[1];
      ad_p1_q <= bus.data_from_master[7:0];
      ad_p2_q <= ad_p1_q;
      ad_p3_q <= ad_p2_q;
    end
  end
  wire ale_fall = ale_d1 & ~ale_s[1];
  wire rd_fall  = rd_d1 & ~rd_s[1];
  wire wr_rise  = ~wr_d1 & wr_s[1];

  // address/data sampled only at strobe edges, when the pins are long settled
  logic [7:0] lat_addr_q;
  logic       lat_cs_n_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lat_addr_q <= 8'h00; lat_cs_n_q <= 1'b1;
    end else if (mode_s[1] && ale_fall) begin
      lat_addr_q <= ad_p3_q;
      lat_cs_n_q <= cs_s[1];
    end
  end
  wire [7:0] cur_addr = mode_s[1] ? lat_addr_q : bus.dedicated_address_pins;
  wire       cur_cs   = mode_s[1] ? ~lat_cs_n_q : ~cs_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctl_q, pol_q, gap_q;
  wire ack_act = ack_s[1] ^ pol_q[EDR_POL_ACK_LOW];
  // single address: acknowledge selects the fifo; dual: address decode does
  wire dual     = ctl_q[EDR_CTL_DUAL];
  wire dma_sel  = ~dual & ack_act;
  wire reg_sel  = cur_cs & ~dma_sel;
  wire fifo_hit = dma_sel | (reg_sel & (cur_addr == EDR_FIFO_ADDR));
  wire wide     = ctl_q[EDR_CTL_WIDE];
  wire do_wr    = wr_rise & (reg_sel | dma_sel);
  wire do_rd    = rd_fall & (reg_sel | dma_sel);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= EDR_CTL_RESET; pol_q <= EDR_POL_RESET; gap_q <= EDR_GAP_RESET;
    end else if (wr_rise && reg_sel) begin
      if (cur_addr == EDR_DMA_TRANSFER_CONTROL_ADDR) begin
        ctl_q <= bus.data_from_master[7:0];
      end else if (cur_addr == EDR_SIGNAL_POLARITY_SELECT_ADDR) begin
        pol_q <= bus.data_from_master[7:0];
      end else if (cur_addr == EDR_REQUEST_GAP_INTERVAL_ADDR) begin
        gap_q <= bus.data_from_master[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first bulk endpoint fifo: 64 bytes
  logic [7:0] mem_q [64];
  logic [6:0] wptr_q, rptr_q, rx_len_q;
  logic       cnt_pending_q;
  logic       txr_q, rxr_q;
  wire fifo_wr = do_wr & fifo_hit & ep_is_in & ~txr_q;
  wire fifo_rd = do_rd & fifo_hit & ~ep_is_in & rxr_q;
  wire [6:0] step = wide ? 7'h2 : 7'h1;
  wire [6:0] wnext = wptr_q + step;
  wire [6:0] rnext = cnt_pending_q ? rptr_q : rptr_q + step;
  wire pkt_wr  = do_wr & reg_sel & (cur_addr == EDR_PKT_READY_ADDR);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= 7'h00;
    end else if (usb_tx_acked || usb_rx_good) begin
      wptr_q <= 7'h00;
    end else if (fifo_wr) begin
      wptr_q <= (wnext > EDR_MAX_PACKET) ? EDR_MAX_PACKET : wnext;
    end
  end
  always_ff @(posedge core_clk) begin
    if (fifo_wr) begin
      mem_q[wptr_q[5:0]] <= bus.data_from_master[7:0];
      if (wide && wptr_q < 7'h3f) begin
        mem_q[wptr_q[5:0] + 6'h1] <= bus.data_from_master[15:8];
      end
    end
  end

  // tx ready: hardware sets at max size, ack clears; set wins over clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txr_q <= 1'b0;
    end else if (fifo_wr && wnext >= EDR_MAX_PACKET) begin
      txr_q <= 1'b1;
    end else if (pkt_wr && bus.data_from_master[EDR_PKT_TX]) begin
      txr_q <= 1'b1;
    end else if (usb_tx_acked) begin
      txr_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxr_q <= 1'b0; rptr_q <= 7'h00; rx_len_q <= 7'h00; cnt_pending_q <= 1'b0;
    end else if (usb_rx_good && !ep_is_in) begin
      rxr_q <= 1'b1;
      rptr_q <= 7'h00;
      rx_len_q <= usb_rx_count;
      cnt_pending_q <= ctl_q[EDR_CTL_COUNT];
    end else if (fifo_rd) begin
      cnt_pending_q <= 1'b0;
      rptr_q <= rnext;
      if (!cnt_pending_q && rnext >= rx_len_q) begin
        rxr_q <= 1'b0;
      end
    end
  end

  function automatic logic [7:0] fifo_byte(input logic [6:0] idx, input logic [6:0] len);
    fifo_byte = (idx < len) ? mem_q[idx[5:0]] : 8'h00;
  endfunction : fifo_byte

  ////////////////////////////////////////////////////////////////////////////
  // read data
  logic [15:0] rdata_q;
  logic        oe_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
    end else if (do_rd) begin
      if (fifo_hit && cnt_pending_q) begin
        rdata_q <= {8'h00, 1'b0, rx_len_q};
      end else if (fifo_hit) begin
        rdata_q <= {wide ? fifo_byte(rptr_q + 7'h1, rx_len_q) : 8'h00,
                    fifo_byte(rptr_q, rx_len_q)};
      end else if (cur_addr == EDR_DMA_TRANSFER_CONTROL_ADDR) begin
        rdata_q <= {8'h00, ctl_q};
      end else if (cur_addr == EDR_SIGNAL_POLARITY_SELECT_ADDR) begin
        rdata_q <= {8'h00, pol_q};
      end else if (cur_addr == EDR_REQUEST_GAP_INTERVAL_ADDR) begin
        rdata_q <= {8'h00, gap_q};
      end else if (cur_addr == EDR_PKT_READY_ADDR) begin
        rdata_q <= {10'h000, txr_q, 3'h0, rxr_q, 1'b0};
      end else if (cur_addr == EDR_STATUS_ADDR) begin
        rdata_q <= {9'h000, wptr_q};
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~rd_s[1] & (reg_sel | dma_sel);
    end
  end
  assign bus.data_from_device = rdata_q;
  assign bus.data_oe_device   = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // request generation
  wire cond = ep_is_in ? ~txr_q : rxr_q;
  wire xfer = fifo_wr | fifo_rd;
  // 13 bits: the largest gap, 1 + 255 * 21 cycles, does not fit in 12
  logic [12:0] gap_cnt_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt_q <= 13'h0000;
    end else if (xfer && !ctl_q[EDR_CTL_DEMAND]) begin
      gap_cnt_q <= 13'(EDR_REQ_EN_CYCLES)
                   + 13'(gap_q) * 13'(EDR_BIT_CYCLES);
    end else if (gap_cnt_q != 13'h0000) begin
      gap_cnt_q <= gap_cnt_q - 13'h0001;
    end
  end
  // halt only masks the request; pointers keep place so resume continues
  // demand mode keeps the request up across units, single mode drops it per unit
  wire req_act = ctl_q[EDR_CTL_ENABLE] & ~ctl_q[EDR_CTL_HALT] & cond
                 & (gap_cnt_q == 13'h0000)
                 & (ctl_q[EDR_CTL_DEMAND] | ~xfer);
  logic req_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= 1'b1;
    end else begin
      req_q <= req_act ^ ~pol_q[EDR_POL_REQ_HIGH];
    end
  end
  assign bus.transfer_request = req_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_packet_ready <= 1'b0; rx_packet_ready <= 1'b0;
    end else begin
      tx_packet_ready <= txr_q; rx_packet_ready <= rxr_q;
    end
  end
endmodule : edr_device

// ==== core/edr_if.sv ====
// interface: local bus and dma handshake between the device and the dma side
`timescale 1ns/1ps
interface edr_if;
  logic        bus_mode_select;
  logic [7:0]  dedicated_address_pins;
  logic [15:0] data_from_master;
  logic [15:0] data_from_device;
  logic        data_oe_device;
  logic        ale;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic        transfer_request;
  logic        transfer_acknowledge;
  modport device (
    input  bus_mode_select, dedicated_address_pins, data_from_master, ale, cs_n, rd_n,
           wr_n, transfer_acknowledge,
    output data_from_device, data_oe_device, transfer_request
  );
  modport master (
    output bus_mode_select, dedicated_address_pins, data_from_master, ale, cs_n, rd_n,
           wr_n, transfer_acknowledge,
    input  data_from_device, data_oe_device, transfer_request
  );
endinterface : edr_if

// ==== core/edr_master.sv ====
// dma side end: command registers driving the local bus cycles toward the device
`timescale 1ns/1ps
module edr_master
  import edr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  edr_if.master           bus,
  input  wire logic [3:0] sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [15:0]     sw_rdata
);
  import edr_pkg::*;
  typedef enum {ST_IDLE, ST_ALE, ST_SETUP, ST_STROBE, ST_HOLD} edr_state_e;
  localparam logic [3:0] EDR_PHASE = 4'h6;

  logic [7:0]  addr_q;
  logic [15:0] data_q, rdata_q;
  logic [1:0]  mode_q;   // bit0 multiplexed bus, bit1 acknowledge polarity low
  logic        dma_q, read_q, busy_q;
  edr_state_e  st_q;
  logic [3:0]  cnt_q;
  logic [15:0] xfer_cnt_q;
  logic [1:0]  req_s;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_s <= 2'h0;
    end else begin
      req_s <= {req_s[0], bus.transfer_request};
    end
  end

  wire start = sw_wr && sw_addr == EDR_HOST_CMD_REG && !busy_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= 8'h00; data_q <= 16'h0000; mode_q <= 2'h0;
    end else if (sw_wr) begin
      if (sw_addr == EDR_HOST_ADDR_REG) begin
        addr_q <= sw_wdata[7:0];
      end else if (sw_addr == EDR_HOST_DATA_REG) begin
        data_q <= sw_wdata;
      end else if (sw_addr == EDR_HOST_MODE_REG) begin
        mode_q <= sw_wdata[1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE; cnt_q <= 4'h0; busy_q <= 1'b0; read_q <= 1'b0; dma_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            read_q <= sw_wdata[1:0] == 2'(EDR_CMD_READ);
            dma_q  <= sw_wdata[2];
            st_q   <= mode_q[0] ? ST_ALE : ST_SETUP;
            cnt_q  <= EDR_PHASE;
          end
        end
        ST_ALE, ST_SETUP, ST_STROBE: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            cnt_q <= EDR_PHASE;
            st_q  <= (st_q == ST_ALE) ? ST_SETUP : (st_q == ST_SETUP) ? ST_STROBE : ST_HOLD;
          end
        end
        default: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q <= ST_IDLE; busy_q <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000; xfer_cnt_q <= 16'h0000;
    end else if (st_q == ST_STROBE && cnt_q == 4'h0) begin
      if (read_q) begin
        rdata_q <= bus.data_from_device;
      end
      xfer_cnt_q <= xfer_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_rdata <= 16'h0000;
    end else if (sw_rd) begin
      if (sw_addr == EDR_HOST_STAT_REG) begin
        sw_rdata <= {14'h0000, req_s[1], busy_q};
      end else if (sw_addr == EDR_HOST_RDATA_REG) begin
        sw_rdata <= rdata_q;
      end else if (sw_addr == EDR_HOST_COUNT_REG) begin
        sw_rdata <= xfer_cnt_q;
      end else begin
        sw_rdata <= 16'h0000;
      end
    end
  end

  // dma cycles in single address mode are selected by acknowledge, not cs
  wire ack_on = dma_q && st_q != ST_IDLE && st_q != ST_ALE;
  assign bus.bus_mode_select        = mode_q[0];
  assign bus.dedicated_address_pins = addr_q;
  assign bus.data_from_master       = (st_q == ST_ALE) ? {8'h00, addr_q} : data_q;
  assign bus.ale                    = st_q == ST_ALE;
  assign bus.cs_n                   = !(st_q != ST_IDLE && !dma_q);
  assign bus.rd_n                   = !(st_q == ST_STROBE && read_q);
  assign bus.wr_n                   = !(st_q == ST_STROBE && !read_q);
  assign bus.transfer_acknowledge   = ack_on ^ mode_q[1];
endmodule : edr_master

// ==== core/edr_pkg.sv ====
// package: register map, field positions and timing for the endpoint dma request logic
package edr_pkg;
  // device register addresses on the local bus
  localparam logic [7:0] EDR_DMA_TRANSFER_CONTROL_ADDR   = 8'h40;
  localparam logic [7:0] EDR_SIGNAL_POLARITY_SELECT_ADDR = 8'h41;
  localparam logic [7:0] EDR_REQUEST_GAP_INTERVAL_ADDR   = 8'h42;
  localparam logic [7:0] EDR_STATUS_ADDR                 = 8'h43;
  localparam logic [7:0] EDR_PKT_READY_ADDR              = 8'h44;
  localparam logic [7:0] EDR_FIFO_ADDR                   = 8'h45;
  // dma_transfer_control fields
  localparam int EDR_CTL_ENABLE  = 0;
  localparam int EDR_CTL_DUAL    = 1;
  localparam int EDR_CTL_COUNT   = 2;
  localparam int EDR_CTL_WIDE    = 3;
  localparam int EDR_CTL_DEMAND  = 4;
  localparam int EDR_CTL_HALT    = 7;
  // signal_polarity_select fields
  localparam int EDR_POL_REQ_HIGH = 1;
  localparam int EDR_POL_ACK_LOW  = 2;
  // packet_ready_flags fields
  localparam int EDR_PKT_RX = 1;
  localparam int EDR_PKT_TX = 5;
  localparam logic [7:0] EDR_CTL_RESET = 8'h00;
  localparam logic [7:0] EDR_POL_RESET = 8'h00;
  localparam logic [7:0] EDR_GAP_RESET = 8'h00;
  localparam logic [6:0] EDR_MAX_PACKET = 7'h40;
  // timing
  localparam int EDR_CLK_PERIOD_PS = 4000;
  localparam int EDR_BIT_TIME_PS   = 84000;
  localparam int EDR_BIT_CYCLES    = EDR_BIT_TIME_PS / EDR_CLK_PERIOD_PS;
  localparam int EDR_REQ_EN_CYCLES = 1;
  // controller command codes
  typedef enum logic [1:0] {
    EDR_CMD_NONE,
    EDR_CMD_WRITE,
    EDR_CMD_READ
  } edr_cmd_e;
  // controller register offsets
  localparam logic [3:0] EDR_HOST_ADDR_REG  = 4'h0;
  localparam logic [3:0] EDR_HOST_DATA_REG  = 4'h1;
  localparam logic [3:0] EDR_HOST_CMD_REG   = 4'h2;
  localparam logic [3:0] EDR_HOST_STAT_REG  = 4'h3;
  localparam logic [3:0] EDR_HOST_COUNT_REG = 4'h4;
  localparam logic [3:0] EDR_HOST_RDATA_REG = 4'h5;
  localparam logic [3:0] EDR_HOST_MODE_REG  = 4'h6;
endpackage : edr_pkg
